// ---- swpt_pin_model.sv ----
`timescale 1ns/1ps
`default_nettype none
module swpt_pin_model
  import swpt_pkg::*;
(
  input wire logic [SWPT_NCH-1:0] wave_out,
  input wire logic [SWPT_NCH-1:0] wave_override,
  input wire logic [SWPT_NCH-1:0] port_out,
  input wire logic [SWPT_NCH-1:0] port_dir,
  output logic [SWPT_NCH-1:0] pin
);
  // port pin level: input pins float to the pull-up, outputs take override or port value
  always_comb begin
    for (int i = 0; i < SWPT_NCH; i++) begin
      if (!port_dir[i]) pin[i] = 1'b1;
      else if (wave_override[i]) pin[i] = wave_out[i];
      else pin[i] = port_out[i];
    end
  end
endmodule // swpt_pin_model
`default_nettype wire

// ---- swpt_pkg.sv ----
`default_nettype none
package swpt_pkg;
  // --------------------------------------------------------------
  // sizes
  // --------------------------------------------------------------
  localparam int SWPT_NCH = 3;
  localparam int SWPT_PW = 10;
  // --------------------------------------------------------------
  // register offsets (byte addresses)
  // --------------------------------------------------------------
  localparam logic [7:0] SWPT_OFF_CTRL_A = 8'h00;
  localparam logic [7:0] SWPT_OFF_CTRL_B = 8'h04;
  localparam logic [7:0] SWPT_OFF_CTRL_E = 8'h08;
  localparam logic [7:0] SWPT_OFF_CTRL_F = 8'h0c;
  localparam logic [7:0] SWPT_OFF_EVCTL = 8'h10;
  localparam logic [7:0] SWPT_OFF_FLAGS = 8'h14;
  localparam logic [7:0] SWPT_OFF_CNT = 8'h18;
  localparam logic [7:0] SWPT_OFF_TOP = 8'h1c;
  localparam logic [7:0] SWPT_OFF_TOPBUF = 8'h20;
  localparam logic [7:0] SWPT_OFF_MATCH0 = 8'h24;
  localparam logic [7:0] SWPT_OFF_MBUF0 = 8'h30;
  // --------------------------------------------------------------
  // field positions
  // --------------------------------------------------------------
  localparam int SWPT_CA_EN = 0;
  localparam int SWPT_CA_PS = 1;
  localparam int SWPT_CB_SHAPE = 0;
  localparam int SWPT_CB_OE = 4;
  localparam int SWPT_CE_DOWN = 0;
  localparam int SWPT_CE_HOLD = 1;
  localparam int SWPT_CF_MBV = 1;
  localparam int SWPT_EV_EN = 0;
  localparam int SWPT_FL_OVF = 3;
  // --------------------------------------------------------------
  // reset values
  // --------------------------------------------------------------
  localparam logic [15:0] SWPT_RST_CNT = 16'h0000;
  localparam logic [15:0] SWPT_RST_TOP = 16'hffff;
  localparam logic [15:0] SWPT_RST_MATCH = 16'h0000;
  // --------------------------------------------------------------
  // types
  // --------------------------------------------------------------
  typedef enum logic [1:0] {
    SWPT_WAVE_NORMAL = 2'b00,
    SWPT_WAVE_FREQ = 2'b01,
    SWPT_WAVE_SINGLE = 2'b11
  } swpt_shape_t;
  typedef struct packed {
    logic psel;
    logic penable;
    logic pwrite;
    logic [7:0] paddr;
    logic [31:0] pwdata;
  } swpt_apb_req_t;
  typedef struct packed {
    logic enable;
    logic [2:0] presc_sel;
    logic [1:0] shape;
    logic [SWPT_NCH-1:0] out_en;
    logic dir_down;
    logic hold;
    logic event_en;
    logic [SWPT_PW-1:0] presc;
    logic [15:0] cnt;
    logic [15:0] top;
    logic [15:0] top_buf;
    logic top_bv;
    logic [SWPT_NCH-1:0][15:0] match;
    logic [SWPT_NCH-1:0][15:0] mbuf;
    logic [SWPT_NCH-1:0] mbv;
    logic [SWPT_NCH-1:0] mflag;
    logic ovf;
    logic [SWPT_NCH-1:0] wave;
    logic [31:0] rdata;
  } swpt_state_t;
endpackage
`default_nettype wire

// ---- swpt_timer.sv ----
// Summary of operation
// - Floor is count zero; ceiling is the highest value of the sequence.
// - Maximum condition flagged when all sixteen count bits are one.
// - At update, valid buffers load working registers unless hold_updates set.
// - Counter steps once per tick in direction from direction bit; single-slope mode always counts up.
// - Counting up from ceiling wraps to zero on next tick.
// - Counting down at floor reloads from the top value.
// - Software count write is immediate and beats count, clear, reload.
// - Direction may change while running; applies to later ticks.
// - Enable starts counting; event mode counts event inputs instead.
// - Top and match buffers have valid flags: set on write, cleared at update.
// - Working match and its buffer both writable; direct write bypasses buffer.
// - Direct top write changes the period at once.
// - Top compared continuously; top below count wraps through full range.
// - Top buffer writable anytime; working top changes only at update or on a direct top write.
// - Match when count equals match value; flag set one tick later.
// - Buffered match value loaded at update, compared from next count.
// - Output drives pin only with waveform mode and channel enable.
// - Toggle mode: channel 0 sets period; outputs toggle on each match.
// - Toggle mode, channel 0 zero, no division: toggle every clock.
// - Prescale select zero means tick on every peripheral clock.
// - Single-slope: count floor to ceiling; set at floor, clear on match.
// - Single-slope: match at floor gives low, above ceiling gives high.
// - Output and flag changes from ceiling, floor, match come next tick.
// - Tick comes from prescaled clock or from event input.
//
// Implementation choices: the APB register port and the placing of the registers.
`timescale 1ns/1ps
`default_nettype none
module swpt_timer
  import swpt_pkg::*;
#(
  parameter int CHANNELS = 3
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire swpt_apb_req_t apb_req,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic event_tick,
  output logic [SWPT_NCH-1:0] wave_out,
  output logic [SWPT_NCH-1:0] wave_override,
  output logic count_at_max
);
  // --------------------------------------------------------------
  // elaboration check
  // --------------------------------------------------------------
  if (CHANNELS != SWPT_NCH) begin : g_bad_channels
    $error("channel count must match the package");
  end

  // --------------------------------------------------------------
  // helpers
  // --------------------------------------------------------------
  // divisor mask: 1,2,4,8,16,64,256,1024
  function automatic logic [SWPT_PW-1:0] presc_mask(input logic [2:0] sel);
    unique case (sel)
      3'h0: presc_mask = 10'h000;
      3'h1: presc_mask = 10'h001;
      3'h2: presc_mask = 10'h003;
      3'h3: presc_mask = 10'h007;
      3'h4: presc_mask = 10'h00f;
      3'h5: presc_mask = 10'h03f;
      3'h6: presc_mask = 10'h0ff;
      3'h7: presc_mask = 10'h3ff;
    endcase
  endfunction

  swpt_state_t q, d;
  logic acc, setup, wr, hit;
  logic tick, up, ceil, flr, upd;
  logic [15:0] top_eff;
  logic [SWPT_NCH-1:0] mhit;
  logic [31:0] rmux;

  // --------------------------------------------------------------
  // tick and compare conditions
  // --------------------------------------------------------------
  // tick source select; mask gates the free prescaler
  assign tick = q.enable & (q.event_en ? event_tick
                : &(q.presc | ~presc_mask(q.presc_sel)));
  assign up = (q.shape == SWPT_WAVE_SINGLE) | ~q.dir_down;
  assign top_eff = (q.shape == SWPT_WAVE_FREQ) ? q.match[0] : q.top;
  assign ceil = (q.cnt == top_eff);
  assign flr = (q.cnt == 16'h0000);
  assign count_at_max = &q.cnt;
  assign upd = tick & (up ? ceil : flr) & ~q.hold;
  assign setup = apb_req.psel & ~apb_req.penable;
  assign acc = apb_req.psel & apb_req.penable;
  assign wr = acc & apb_req.pwrite;

  // per-channel match compare
  always_comb begin
    for (int i = 0; i < SWPT_NCH; i++) begin
      mhit[i] = (q.cnt == q.match[i]);
    end
  end

  // --------------------------------------------------------------
  // read mux and address decode
  // --------------------------------------------------------------
  always_comb begin
    rmux = 32'h0000_0000;
    hit = 1'b1;
    unique case (apb_req.paddr)
      SWPT_OFF_CTRL_A: rmux = {28'h0, q.presc_sel, q.enable};
      SWPT_OFF_CTRL_B: rmux = {25'h0, q.out_en, 2'h0, q.shape};
      SWPT_OFF_CTRL_E: rmux = {30'h0, q.hold, q.dir_down};
      SWPT_OFF_CTRL_F: rmux = {28'h0, q.mbv, q.top_bv};
      SWPT_OFF_EVCTL: rmux = {31'h0, q.event_en};
      SWPT_OFF_FLAGS: rmux = {28'h0, q.ovf, q.mflag};
      SWPT_OFF_CNT: rmux = {16'h0, q.cnt};
      SWPT_OFF_TOP: rmux = {16'h0, q.top};
      SWPT_OFF_TOPBUF: rmux = {16'h0, q.top_buf};
      default: hit = 1'b0;
    endcase
    for (int i = 0; i < SWPT_NCH; i++) begin
      if (apb_req.paddr == SWPT_OFF_MATCH0 + 8'(4 * i)) begin
        rmux = {16'h0, q.match[i]};
        hit = 1'b1;
      end
      if (apb_req.paddr == SWPT_OFF_MBUF0 + 8'(4 * i)) begin
        rmux = {16'h0, q.mbuf[i]};
        hit = 1'b1;
      end
    end
  end

  // --------------------------------------------------------------
  // next state
  // --------------------------------------------------------------
  always_comb begin
    d = q;
    // free prescaler, held at zero while stopped
    d.presc = q.enable ? SWPT_PW'(q.presc + 1'b1) : '0;
    // base counter step
    if (tick) begin
      if (up) begin
        d.cnt = ceil ? 16'h0000 : 16'(q.cnt + 16'h0001);
      end else begin
        d.cnt = flr ? top_eff : 16'(q.cnt - 16'h0001);
      end
    end
    // buffered loads at the update condition
    if (upd) begin
      if (q.top_bv) begin
        d.top = q.top_buf;
      end
      d.top_bv = 1'b0;
      for (int i = 0; i < SWPT_NCH; i++) begin
        if (q.mbv[i]) begin
          d.match[i] = q.mbuf[i];
        end
        d.mbv[i] = 1'b0;
      end
    end
    // waveform update on tick, from the state reached before it
    if (tick) begin
      for (int i = 0; i < SWPT_NCH; i++) begin
        unique case (q.shape)
          SWPT_WAVE_FREQ: begin
            if (mhit[i]) begin
              d.wave[i] = ~q.wave[i];
            end
          end
          SWPT_WAVE_SINGLE: begin
            if (mhit[i]) begin
              d.wave[i] = 1'b0;
            end else if (flr) begin
              d.wave[i] = 1'b1;
            end
          end
          default: d.wave[i] = q.wave[i];
        endcase
      end
    end
    // register writes; these win over the counter and update logic
    if (wr) begin
      unique case (apb_req.paddr)
        SWPT_OFF_CTRL_A: begin
          d.enable = apb_req.pwdata[SWPT_CA_EN];
          d.presc_sel = apb_req.pwdata[SWPT_CA_PS +: 3];
        end
        SWPT_OFF_CTRL_B: begin
          d.shape = apb_req.pwdata[SWPT_CB_SHAPE +: 2];
          d.out_en = apb_req.pwdata[SWPT_CB_OE +: SWPT_NCH];
        end
        SWPT_OFF_CTRL_E: begin
          d.dir_down = apb_req.pwdata[SWPT_CE_DOWN];
          d.hold = apb_req.pwdata[SWPT_CE_HOLD];
        end
        SWPT_OFF_EVCTL: d.event_en = apb_req.pwdata[SWPT_EV_EN];
        SWPT_OFF_FLAGS: begin
          d.mflag = q.mflag & ~apb_req.pwdata[SWPT_NCH-1:0];
          d.ovf = q.ovf & ~apb_req.pwdata[SWPT_FL_OVF];
        end
        SWPT_OFF_CNT: d.cnt = apb_req.pwdata[15:0];
        SWPT_OFF_TOP: d.top = apb_req.pwdata[15:0];
        SWPT_OFF_TOPBUF: begin
          d.top_buf = apb_req.pwdata[15:0];
          d.top_bv = 1'b1;
        end
        default: d.enable = q.enable;
      endcase
      for (int i = 0; i < SWPT_NCH; i++) begin
        if (apb_req.paddr == SWPT_OFF_MATCH0 + 8'(4 * i)) begin
          d.match[i] = apb_req.pwdata[15:0];
        end
        if (apb_req.paddr == SWPT_OFF_MBUF0 + 8'(4 * i)) begin
          d.mbuf[i] = apb_req.pwdata[15:0];
          d.mbv[i] = 1'b1;
        end
      end
    end
    // sticky flags; a set beats a clear in the same cycle
    if (tick) begin
      for (int i = 0; i < SWPT_NCH; i++) begin
        if (mhit[i]) begin
          d.mflag[i] = 1'b1;
        end
      end
      if (up ? ceil : flr) begin
        d.ovf = 1'b1;
      end
    end
    // read data captured in the setup phase
    if (setup) begin
      d.rdata = rmux;
    end
  end

  // state register
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      q <= '{enable: 1'b0, presc_sel: 3'h0, shape: SWPT_WAVE_NORMAL,
             out_en: '0, dir_down: 1'b0, hold: 1'b0, event_en: 1'b0,
             presc: '0, cnt: SWPT_RST_CNT, top: SWPT_RST_TOP,
             top_buf: SWPT_RST_TOP, top_bv: 1'b0,
             match: {SWPT_NCH{SWPT_RST_MATCH}},
             mbuf: {SWPT_NCH{SWPT_RST_MATCH}}, mbv: '0, mflag: '0,
             ovf: 1'b0, wave: '0, rdata: 32'h0000_0000};
    end else begin
      q <= d;
    end
  end

  // --------------------------------------------------------------
  // outputs
  // --------------------------------------------------------------
  assign prdata = q.rdata;
  assign pready = 1'b1;
  assign pslverr = acc & ~hit;
  assign wave_out = q.wave;
  // pin override only with a waveform mode and channel enable
  assign wave_override = (q.shape == SWPT_WAVE_NORMAL) ? '0 : q.out_en;

  // --------------------------------------------------------------
  // assertions
  // --------------------------------------------------------------
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  // write strobes decoded per register
  logic wr_cnt, wr_top, wr_topbuf, wr_flags, wr_match0, wr_mbuf0;
  assign wr_cnt = wr & (apb_req.paddr == SWPT_OFF_CNT);
  assign wr_top = wr & (apb_req.paddr == SWPT_OFF_TOP);
  assign wr_topbuf = wr & (apb_req.paddr == SWPT_OFF_TOPBUF);
  assign wr_flags = wr & (apb_req.paddr == SWPT_OFF_FLAGS);
  assign wr_match0 = wr & (apb_req.paddr == SWPT_OFF_MATCH0);
  assign wr_mbuf0 = wr & (apb_req.paddr == SWPT_OFF_MBUF0);

  // counter stepping and tick source
  // a count write in the same cycle wins, so stepping checks leave it out
  a_up_wrap_zero: assert property (tick && up && ceil && !wr_cnt |=> q.cnt == 16'h0000)
    else $error("count did not wrap to zero at ceiling");
  a_down_reload: assert property (
    tick && !up && flr && !wr_cnt && q.shape == SWPT_WAVE_NORMAL |=> q.cnt == $past(top_eff))
    else $error("count not reloaded from top at floor");
  a_up_step: assert property (
    tick && up && !ceil && !wr_cnt |=> q.cnt == $past(q.cnt) + 16'h0001)
    else $error("count did not step up");
  a_down_step: assert property (
    tick && !up && !flr && !wr_cnt |=> q.cnt == $past(q.cnt) - 16'h0001)
    else $error("count did not step down");
  a_single_up: assert property (
    q.shape == SWPT_WAVE_SINGLE && tick && !ceil && !wr_cnt |=> q.cnt == $past(q.cnt) + 16'h0001)
    else $error("single-slope count did not step up");
  a_cnt_write_wins: assert property (wr_cnt |=> q.cnt == $past(apb_req.pwdata[15:0]))
    else $error("count write did not take effect");
  a_idle_hold: assert property (
    !q.enable && !wr_cnt |=> $stable(q.cnt))
    else $error("count moved while disabled");
  a_event_source: assert property (
    q.enable && q.event_en |-> tick == event_tick)
    else $error("event mode tick does not follow event input");
  a_nodiv_tick: assert property (
    q.enable && !q.event_en && q.presc_sel == 3'h0 |-> tick)
    else $error("no tick with division of one");
  a_div_two: assert property (
    q.enable && !q.event_en && q.presc_sel == 3'h1 |-> tick == q.presc[0])
    else $error("divide by two tick misplaced");
  a_div_four: assert property (
    q.enable && !q.event_en && q.presc_sel == 3'h2 |-> tick == &q.presc[1:0])
    else $error("divide by four tick misplaced");
  a_presc_stop: assert property (!q.enable |=> q.presc == '0)
    else $error("prescaler ran while disabled");

  // register writes and buffered updates
  // working values move only at update or on a direct write
  a_hold_keeps_top: assert property (q.hold && !wr_top |=> $stable(q.top))
    else $error("top changed while updates held");
  a_hold_keeps_match: assert property (
    q.hold && !wr_match0 |=> $stable(q.match[0]))
    else $error("match value changed while updates held");
  a_topbuf_valid: assert property (
    wr_topbuf |=> q.top_bv ##0 q.top_buf == $past(apb_req.pwdata[15:0]))
    else $error("top buffer valid not set on write");
  a_mbuf_valid: assert property (wr_mbuf0 |=> q.mbv[0])
    else $error("match buffer valid not set on write");
  a_buf_clear: assert property (
    upd && !wr_topbuf |=> !q.top_bv)
    else $error("top buffer valid not cleared at update");
  a_top_write: assert property (
    wr_top |=> q.top == $past(apb_req.pwdata[15:0]))
    else $error("direct top write not immediate");
  a_top_stable: assert property (
    !upd && !wr_top |=> $stable(q.top))
    else $error("top changed outside update");
  a_top_update: assert property (
    upd && q.top_bv && !wr_top |=> q.top == $past(q.top_buf))
    else $error("top not loaded from buffer at update");
  a_match_write: assert property (
    wr_match0 |=> q.match[0] == $past(apb_req.pwdata[15:0]))
    else $error("direct match write not taken");
  a_match_update: assert property (
    upd && q.mbv[0] && !wr_match0 |=> q.match[0] == $past(q.mbuf[0]))
    else $error("match not loaded from buffer at update");

  // flags and waveforms
  // effects of a tick show one edge later, from the state before it
  a_match_flag: assert property (tick && mhit[0] |=> q.mflag[0])
    else $error("match flag not set one tick after match");
  a_flag_sticky: assert property (
    q.mflag[0] && !wr_flags |=> q.mflag[0])
    else $error("match flag dropped without a clear");
  a_wrap_flag: assert property (
    tick && (up ? ceil : flr) |=> q.ovf)
    else $error("wrap flag not set one tick after wrap");
  a_freq_top: assert property (
    q.shape == SWPT_WAVE_FREQ && tick && !q.dir_down && q.cnt == q.match[0] && !wr_cnt
    |=> q.cnt == 16'h0000)
    else $error("toggle mode period not set by channel zero");
  a_freq_toggle: assert property (
    q.shape == SWPT_WAVE_FREQ && tick |=> (q.wave ^ $past(q.wave)) == $past(mhit))
    else $error("toggle output did not follow its matches");
  a_pwm_clear: assert property (
    q.shape == SWPT_WAVE_SINGLE && tick |=> (q.wave & $past(mhit)) == '0)
    else $error("single-slope output not cleared on match");
  a_pwm_floor: assert property (
    q.shape == SWPT_WAVE_SINGLE && tick && flr |=> q.wave == ~$past(mhit))
    else $error("single-slope floor level wrong");
  a_wave_steady: assert property (
    !tick |=> $stable(q.wave))
    else $error("waveform changed without a tick");
  a_override_gate: assert property (
    q.shape == SWPT_WAVE_NORMAL |-> wave_override == '0)
    else $error("pin overridden without waveform mode");

  // main scenarios
  c_up_wrap: cover property (tick && up && ceil ##1 q.cnt == 16'h0000);
  c_buffered_update: cover property (upd && q.top_bv);
  c_match_buffer: cover property (upd && q.mbv[0]);
  c_pwm_cycle: cover property (q.shape == SWPT_WAVE_SINGLE && q.wave[0] ##[1:40] !q.wave[0]);
  c_freq_fast: cover property (q.shape == SWPT_WAVE_FREQ && tick && mhit[0] [*3]);
endmodule // swpt_timer
`default_nettype wire

// ---- swpt_timer_tb.sv ----
`timescale 1ns/1ps
`default_nettype none
module swpt_timer_tb
  import swpt_pkg::*;
;
  // --------------------------------------------------------------
  // stimulus and wiring
  // --------------------------------------------------------------
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  swpt_apb_req_t req = '0;
  logic event_tick = 1'b0;
  logic [SWPT_NCH-1:0] port_out = 3'h2;
  logic [SWPT_NCH-1:0] port_dir = 3'h3;
  logic [31:0] prdata;
  logic pready;
  logic pslverr;
  logic count_at_max;
  logic [SWPT_NCH-1:0] wave_out;
  logic [SWPT_NCH-1:0] wave_override;
  logic [SWPT_NCH-1:0] pin;
  logic [31:0] rd;
  logic err;
  int n_fail = 0;
  int compares = 0;
  int cycles = 0;
  int t;
  int h;
  // 50 MHz clock
  always #10 pclk = ~pclk;
  swpt_timer #(.CHANNELS(3)) swpt_timer_inst (.pclk(pclk), .presetn(presetn), .apb_req(req),
    .prdata(prdata), .pready(pready), .pslverr(pslverr), .event_tick(event_tick),
    .wave_out(wave_out), .wave_override(wave_override), .count_at_max(count_at_max));
  swpt_pin_model swpt_pin_model_inst (.wave_out(wave_out), .wave_override(wave_override),
    .port_out(port_out), .port_dir(port_dir), .pin(pin));
  // --------------------------------------------------------------
  // helpers
  // --------------------------------------------------------------
  task automatic tally_and_finish();
    if (n_fail == 0 && compares > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask
  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    compares++;
    if (got !== exp) begin
      n_fail++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  // one apb transfer, held until pready is seen high at an edge
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    @(posedge pclk);
    req <= '{psel: 1'b1, penable: 1'b0, pwrite: wr, paddr: a, pwdata: d};
    @(posedge pclk);
    req.penable <= 1'b1;
    do @(posedge pclk);
    while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    req <= '0;
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
  endtask
  task automatic rd_chk(input logic [7:0] a, input logic [31:0] exp, input logic [31:0] m);
    apb(1'b0, a, 32'h0);
    check(rd & m, exp);
  endtask
  // one event input pulse, seen by the timer at one edge
  task automatic tick_once();
    @(posedge pclk);
    event_tick <= 1'b1;
    @(posedge pclk);
    event_tick <= 1'b0;
  endtask
  // toggles and high cycles of one output over n settled samples
  task automatic watch(input int ch, input int n, output int tg, output int hi);
    logic p;
    tg = 0;
    hi = 0;
    @(negedge pclk);
    p = wave_out[ch];
    repeat (n) begin
      @(negedge pclk);
      if (wave_out[ch] !== p) tg++;
      if (wave_out[ch] === 1'b1) hi++;
      p = wave_out[ch];
    end
  endtask
  // hang guard
  always @(posedge pclk) begin
    cycles <= cycles + 1;
    if (cycles == 20000) begin
      n_fail++;
      tally_and_finish();
    end
  end
  // --------------------------------------------------------------
  // main sequence
  // --------------------------------------------------------------
  initial begin
    repeat (4) @(posedge pclk);
    presetn <= 1'b1;
    @(negedge pclk);
    check(32'(wave_override), 32'h0);
    rd_chk(SWPT_OFF_CNT, 32'h0, 32'hffff);
    rd_chk(SWPT_OFF_TOP, 32'hffff, 32'hffff);
    apb(1'b0, 8'hfc, 32'h0);
    check(32'(err), 32'h1);
    // event-driven stepping: each pulse is one tick
    wr(SWPT_OFF_EVCTL, 32'h1);
    wr(SWPT_OFF_CTRL_A, 32'h1);
    wr(SWPT_OFF_TOP, 32'h10);
    wr(SWPT_OFF_CNT, 32'h0);
    wr(SWPT_OFF_CTRL_E, 32'h1);
    tick_once();
    rd_chk(SWPT_OFF_CNT, 32'h10, 32'hffff);
    tick_once();
    rd_chk(SWPT_OFF_CNT, 32'hf, 32'hffff);
    wr(SWPT_OFF_CTRL_E, 32'h0);
    tick_once();
    rd_chk(SWPT_OFF_CNT, 32'h10, 32'hffff);
    tick_once();
    rd_chk(SWPT_OFF_CNT, 32'h0, 32'hffff);
    wr(SWPT_OFF_CNT, 32'h8);
    wr(SWPT_OFF_TOP, 32'h5);
    tick_once();
    rd_chk(SWPT_OFF_CNT, 32'h9, 32'hffff);
    // buffered top: loads only at the update condition
    wr(SWPT_OFF_TOPBUF, 32'h3);
    rd_chk(SWPT_OFF_CTRL_F, 32'h1, 32'h1);
    rd_chk(SWPT_OFF_TOP, 32'h5, 32'hffff);
    wr(SWPT_OFF_CNT, 32'h5);
    tick_once();
    rd_chk(SWPT_OFF_TOP, 32'h3, 32'hffff);
    rd_chk(SWPT_OFF_CTRL_F, 32'h0, 32'h1);
    wr(SWPT_OFF_CTRL_E, 32'h2);
    wr(SWPT_OFF_TOPBUF, 32'h7);
    wr(SWPT_OFF_CNT, 32'h3);
    tick_once();
    rd_chk(SWPT_OFF_TOP, 32'h3, 32'hffff);
    wr(SWPT_OFF_CTRL_E, 32'h0);
    // buffered match 0: pending until the next update
    wr(SWPT_OFF_MBUF0, 32'h4);
    rd_chk(SWPT_OFF_CTRL_F, 32'h2, 32'h2);
    rd_chk(SWPT_OFF_MATCH0, 32'h0, 32'hffff);
    // match flag one tick after equality
    wr(SWPT_OFF_MATCH0 + 8'h04, 32'h2);
    rd_chk(SWPT_OFF_MATCH0 + 8'h04, 32'h2, 32'hffff);
    wr(SWPT_OFF_FLAGS, 32'hf);
    wr(SWPT_OFF_CNT, 32'h2);
    tick_once();
    rd_chk(SWPT_OFF_FLAGS, 32'h2, 32'h7);
    wr(SWPT_OFF_TOP, 32'hffff);
    wr(SWPT_OFF_CNT, 32'hfffe);
    tick_once();
    @(negedge pclk);
    check(32'(count_at_max), 32'h1);
    tick_once();
    @(negedge pclk);
    check(32'(count_at_max), 32'h0);
    rd_chk(SWPT_OFF_MATCH0, 32'h4, 32'hffff);
    rd_chk(SWPT_OFF_CTRL_F, 32'h0, 32'h2);
    // toggle mode at three prescale settings
    wr(SWPT_OFF_CTRL_A, 32'h0);
    wr(SWPT_OFF_EVCTL, 32'h0);
    wr(SWPT_OFF_MATCH0, 32'h0);
    wr(SWPT_OFF_CNT, 32'h0);
    wr(SWPT_OFF_CTRL_B, 32'h11);
    for (int ps = 0; ps < 3; ps++) begin
      wr(SWPT_OFF_CTRL_A, 32'(ps * 2 + 1));
      watch(0, 16, t, h);
      check(32'(t), 32'(16 >> ps));
    end
    check(32'(pin), {29'h0, 1'b1, port_out[1], wave_out[0]});
    // single slope: top 3, matches 1, 0 and above top
    wr(SWPT_OFF_CTRL_A, 32'h0);
    wr(SWPT_OFF_TOP, 32'h3);
    wr(SWPT_OFF_MATCH0, 32'h1);
    wr(SWPT_OFF_MATCH0 + 8'h04, 32'h0);
    wr(SWPT_OFF_MATCH0 + 8'h08, 32'h5);
    wr(SWPT_OFF_CNT, 32'h0);
    wr(SWPT_OFF_CTRL_B, 32'h73);
    wr(SWPT_OFF_CTRL_A, 32'h1);
    watch(0, 8, t, h);
    watch(0, 8, t, h);
    check(32'(h), 32'h2);
    watch(1, 8, t, h);
    check(32'(h), 32'h0);
    watch(2, 8, t, h);
    check(32'(h), 32'h8);
    check(32'(wave_override), 32'h7);
    tally_and_finish();
  end
endmodule // swpt_timer_tb
`default_nettype wire
